//--- sim/dsp_ctrl_checker.sv
// checker: pin relations of dsp_ctrl
// assumes bind to dsp_ctrl; all sampled on REF_CLK
`timescale 1ns/10ps
module dsp_ctrl_checker (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic LINK_LATCH,
  input wire logic CARD_RESET,
  input wire logic CARD_RESET_N,
  input wire logic [3:0] OVERCURRENT_SENSE,
  input wire logic OVER_TEMP,
  input wire logic [3:0] BELOW_GROUND,
  input wire logic [1:0] PROG_OUT_OF_LIMIT,
  input wire dsp_pkg::dsp_slot_t SLOT_A_CFG,
  input wire dsp_pkg::dsp_slot_t SLOT_B_CFG,
  input wire logic [3:0] CURRENT_LIMIT_EN,
  input wire logic LOW_QUIESCENT,
  input wire logic OVERCURRENT_FLAG_N,
  input wire logic SLOT_A_POWER_READY,
  input wire logic SLOT_B_POWER_READY
);
  import dsp_pkg::*;
  wire [11:0] cfg = {SLOT_A_CFG, SLOT_B_CFG};
  wire calm = !CARD_RESET && CARD_RESET_N;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // windows of six cycles cover the input synchronisers
  AST_FLAG_LOW: assert property ((|OVERCURRENT_SENSE)[*6] |-> !OVERCURRENT_FLAG_N)
    else $error("flag missed overcurrent");
  AST_FLAG_HIGH: assert property ((OVERCURRENT_SENSE == 4'h0)[*6] |-> OVERCURRENT_FLAG_N)
    else $error("flag low without overcurrent");
  AST_LIMIT: assert property ($stable(OVERCURRENT_SENSE)[*6] |-> CURRENT_LIMIT_EN == OVERCURRENT_SENSE)
    else $error("wrong output limited");
  AST_READY: assert property ($stable(PROG_OUT_OF_LIMIT)[*6] |->
    {SLOT_B_POWER_READY, SLOT_A_POWER_READY} == PROG_OUT_OF_LIMIT)
    else $error("power ready wrong");
  AST_RST_HIGH: assert property (CARD_RESET[*6] |-> cfg == 12'h249)
    else $error("card reset not grounding");
  AST_RST_LOW: assert property ((!CARD_RESET_N)[*6] |-> cfg == 12'h249)
    else $error("low reset not grounding");
  AST_HOT: assert property ((OVER_TEMP && calm)[*6] |-> cfg == 12'h000)
    else $error("outputs on while hot");
  AST_QUIET: assert property (LOW_QUIESCENT[*2] |-> cfg == 12'h000)
    else $error("outputs on in shutdown");
  // a latch rise is the only thing that may move the settings here
  AST_HOLD: assert property ((!LINK_LATCH && !OVER_TEMP && calm && BELOW_GROUND == 4'h0)[*8]
    |=> $stable(cfg))
    else $error("settings moved without latch");
endmodule

bind dsp_ctrl dsp_ctrl_checker chk (.REF_CLK(REF_CLK), .RSTN(RSTN), .LINK_LATCH(LINK_LATCH),
  .CARD_RESET(CARD_RESET), .CARD_RESET_N(CARD_RESET_N), .OVER_TEMP(OVER_TEMP),
  .OVERCURRENT_SENSE(OVERCURRENT_SENSE), .BELOW_GROUND(BELOW_GROUND),
  .PROG_OUT_OF_LIMIT(PROG_OUT_OF_LIMIT), .SLOT_A_CFG(SLOT_A_CFG), .SLOT_B_CFG(SLOT_B_CFG),
  .CURRENT_LIMIT_EN(CURRENT_LIMIT_EN), .LOW_QUIESCENT(LOW_QUIESCENT),
  .OVERCURRENT_FLAG_N(OVERCURRENT_FLAG_N), .SLOT_A_POWER_READY(SLOT_A_POWER_READY),
  .SLOT_B_POWER_READY(SLOT_B_POWER_READY));

//--- sim/dsp_link_model.sv
// serial controller model driving the three-wire link
// assumes send is called only while the link is idle
`timescale 1ns/10ps
module dsp_link_model (
  output logic link_clk,
  output logic link_data,
  output logic link_latch
);
  initial begin
    link_clk = 1'b0;
    link_data = 1'b1;
    link_latch = 1'b0;
  end
  // 30 ns bit period; clock stands low between frames
  task automatic send(input logic [8:0] w);
    #7;
    for (int i = 8; i >= 0; i--) begin
      link_data = w[i];
      #15 link_clk = 1'b1;
      #15 link_clk = 1'b0;
    end
    #5 link_latch = 1'b1;
    // latch is sampled by the link clock, so it keeps running; data toggles
    repeat (4) begin
      #10 link_clk = 1'b1;
      #15 link_clk = 1'b0;
      #5 link_data = ~link_data;
    end
    link_latch = 1'b0;
  endtask
endmodule

//--- sim/testbench.sv
// self-checking bench for dsp_ctrl
// assumes the link model and checker are compiled alongside
`timescale 1ns/10ps
module testbench;
  import dsp_pkg::*;
  logic REF_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic CARD_RESET = 1'b0;
  logic CARD_RESET_N = 1'b1;
  logic OVER_TEMP = 1'b0;
  logic [3:0] OVERCURRENT_SENSE = 4'h0;
  logic [3:0] BELOW_GROUND = 4'h0;
  logic [1:0] PROG_OUT_OF_LIMIT = 2'h0;
  logic LINK_CLK, LINK_DATA, LINK_LATCH, LOW_QUIESCENT, OVERCURRENT_FLAG_N;
  logic SLOT_A_POWER_READY, SLOT_B_POWER_READY;
  logic [3:0] CURRENT_LIMIT_EN;
  dsp_slot_t SLOT_A_CFG, SLOT_B_CFG;
  int fail_count = 0;
  int checked = 0;
  logic [8:0] word;
  dsp_link_model LM (.link_clk(LINK_CLK), .link_data(LINK_DATA), .link_latch(LINK_LATCH));
  dsp_ctrl DUT (.REF_CLK(REF_CLK), .RSTN(RSTN), .LINK_CLK(LINK_CLK), .LINK_DATA(LINK_DATA),
    .LINK_LATCH(LINK_LATCH), .CARD_RESET(CARD_RESET), .CARD_RESET_N(CARD_RESET_N),
    .OVERCURRENT_SENSE(OVERCURRENT_SENSE), .OVER_TEMP(OVER_TEMP), .BELOW_GROUND(BELOW_GROUND),
    .PROG_OUT_OF_LIMIT(PROG_OUT_OF_LIMIT), .SLOT_A_CFG(SLOT_A_CFG), .SLOT_B_CFG(SLOT_B_CFG),
    .CURRENT_LIMIT_EN(CURRENT_LIMIT_EN), .LOW_QUIESCENT(LOW_QUIESCENT),
    .OVERCURRENT_FLAG_N(OVERCURRENT_FLAG_N), .SLOT_A_POWER_READY(SLOT_A_POWER_READY),
    .SLOT_B_POWER_READY(SLOT_B_POWER_READY));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge REF_CLK);
    #2;
  endtask
  // main code 01 is 3 V, 10 is 5 V; prog 01 copies main
  function automatic dsp_slot_t dec(input logic [1:0] m, input logic [1:0] p);
    dsp_sel_t ms;
    ms = (m == 2'b01) ? DSP_V3 : (m == 2'b10) ? DSP_V5 : DSP_GND;
    return {ms, (p == 2'b00) ? DSP_GND : (p == 2'b01) ? ms : (p == 2'b10) ? DSP_V12 : DSP_HIZ};
  endfunction
  function automatic logic [11:0] expw(input logic [8:0] w);
    return w[8] ? {dec({w[3], w[2]}, {w[0], w[1]}), dec({w[6], w[7]}, {w[4], w[5]})} : 12'h000;
  endfunction
  task automatic load(input logic [8:0] w);
    word = w;
    LM.send(w);
    step(12);
    chk({SLOT_A_CFG, SLOT_B_CFG}, expw(w));
    chk({11'h000, LOW_QUIESCENT}, {11'h000, !w[8]});
  endtask
  initial begin
    forever #50 REF_CLK = ~REF_CLK;
  end
  // generous limit: the whole run needs under 60 us
  initial begin
    #400000;
    fail_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'hD99A49E3));
    step(16);
    RSTN = 1'b1;
    step(4);
    chk({SLOT_A_CFG, SLOT_B_CFG}, 12'h000);
    for (int i = 0; i < 16; i++) begin
      load({1'b1, 4'(i), 4'(i)});
    end
    repeat (8) load(9'($urandom));
    $display("decode test done");
    load(9'h1EA);
    for (int j = 0; j < 4; j++) begin
      OVERCURRENT_SENSE = 4'h1 << j;
      PROG_OUT_OF_LIMIT = 2'(j);
      step(6);
      chk({8'h00, CURRENT_LIMIT_EN}, {8'h00, OVERCURRENT_SENSE});
      chk({SLOT_A_CFG, SLOT_B_CFG}, expw(word));
      chk({10'h000, SLOT_B_POWER_READY, SLOT_A_POWER_READY}, {10'h000, 2'(j)});
      chk({11'h000, OVERCURRENT_FLAG_N}, 12'h000);
    end
    OVERCURRENT_SENSE = 4'h0;
    step(6);
    chk({11'h000, OVERCURRENT_FLAG_N}, 12'h001);
    $display("fault test done");
    OVER_TEMP = 1'b1;
    step(6);
    chk({SLOT_A_CFG, SLOT_B_CFG}, 12'h000);
    OVER_TEMP = 1'b0;
    step(6);
    chk({SLOT_A_CFG, SLOT_B_CFG}, expw(word));
    // one reset input active at a time, the other held idle
    for (int r = 0; r < 2; r++) begin
      {CARD_RESET, CARD_RESET_N} = r ? 2'b00 : 2'b11;
      step(6);
      chk({SLOT_A_CFG, SLOT_B_CFG}, 12'h249);
      {CARD_RESET, CARD_RESET_N} = 2'b01;
      step(6);
      chk({SLOT_A_CFG, SLOT_B_CFG}, expw(word));
    end
    BELOW_GROUND = 4'h4;
    step(6);
    BELOW_GROUND = 4'h0;
    step(6);
    chk({SLOT_A_CFG, SLOT_B_CFG}, 12'h000);
    RSTN = 1'b0;
    step(2);
    RSTN = 1'b1;
    load(9'h1EA);
    $display("protect test done");
    stop_test();
  end
endmodule

//--- src/dsp_consts.svh
// constants for the dual-slot card power serial control block
// assumes inclusion by the top module only
`ifndef DSP_CONSTS_SVH
`define DSP_CONSTS_SVH
`define DSP_WORD_W 9
`define DSP_BIT_PON 8
`define DSP_BIT_A_PROG_HI 0
`define DSP_BIT_A_PROG_LO 1
`define DSP_BIT_A_MAIN_LO 2
`define DSP_BIT_A_MAIN_HI 3
`define DSP_BIT_B_PROG_HI 4
`define DSP_BIT_B_PROG_LO 5
`define DSP_BIT_B_MAIN_HI 6
`define DSP_BIT_B_MAIN_LO 7
`define DSP_WORD_RST 9'h000
`endif

//--- src/dsp_ctrl.sv
// dual-slot card power control: serial word in, switch settings out
// assumes LINK_CLK is the serial clock pin; latch and resets are async pins
`timescale 1ns/10ps
`include "dsp_consts.svh"

// How it works
// - shift data in on serial clock rise
// - latch rise loads nine bits into word
// - shutdown bit zero floats all outputs unless a card reset grounds them
// - slot a prog from bits 0,1
// - slot b prog from bits 4,5
// - follow setting tracks own main output
// - slot b follow takes slot b main
// - slot a main from bits 3,2
// - slot b main from bits 6,7
// - overcurrent flag low on any overcurrent input
// - only faulted output is limited
// - thermal event turns all outputs off unless a card reset grounds them
// - below-ground latches off until power cycle
// - reset grounds main and prog outputs
// - low reset input acts like high one
// - power ready low while prog in limits
module dsp_ctrl (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic LINK_CLK,
  input wire logic LINK_DATA,
  input wire logic LINK_LATCH,
  input wire logic CARD_RESET,
  input wire logic CARD_RESET_N,
  input wire logic [3:0] OVERCURRENT_SENSE,
  input wire logic OVER_TEMP,
  input wire logic [3:0] BELOW_GROUND,
  input wire logic [1:0] PROG_OUT_OF_LIMIT,
  output dsp_pkg::dsp_slot_t SLOT_A_CFG,
  output dsp_pkg::dsp_slot_t SLOT_B_CFG,
  output logic [3:0] CURRENT_LIMIT_EN,
  output logic LOW_QUIESCENT,
  output logic OVERCURRENT_FLAG_N,
  output logic SLOT_A_POWER_READY,
  output logic SLOT_B_POWER_READY
);
  import dsp_pkg::*;

  logic [10:0] shift_r;
  logic [10:0] shift_nxt;
  logic [8:0] word_r;
  logic [8:0] word_nxt;
  logic [8:0] word_sync1_r;
  logic [8:0] word_sync2_r;
  logic latch_meta_r;
  logic latch_sync_r;
  logic latch_prev_r;
  logic latch_tog_r;
  logic tog_meta_r;
  logic tog_sync_r;
  logic tog_prev_r;
  logic [8:0] ctrl_r;
  logic [8:0] ctrl_nxt;
  logic [1:0] rst_meta_r;
  logic [1:0] rst_sync_r;
  logic [3:0] oc_meta_r;
  logic [3:0] oc_sync_r;
  logic temp_meta_r;
  logic temp_sync_r;
  logic [3:0] bg_meta_r;
  logic [3:0] bg_sync_r;
  logic [1:0] pl_meta_r;
  logic [1:0] pl_sync_r;
  logic dead_r;
  logic dead_nxt;
  logic card_rst;
  logic latch_rise;
  logic pon;
  dsp_slot_t a_nxt;
  dsp_slot_t b_nxt;
  dsp_slot_t a_r;
  dsp_slot_t b_r;
  logic [3:0] lim_r;
  logic quiet_r;
  logic oc_n_r;
  logic [1:0] rdy_r;

  // link domain: shift register, new bit enters at bit 0
  // two spare bits, since the latch is seen two clock rises late
  // sample on rise
  always_comb begin
    shift_nxt = {shift_r[9:0], LINK_DATA};
  end

  // no reset on the link side: the serial clock may stand still
  always_ff @(posedge LINK_CLK) begin
    shift_r <= shift_nxt;
  end

  // latch pin is sampled with the link clock; relies on the controller
  // raising it before the next clock rise, which the clock keeps running
  // latch before next rise
  always_ff @(posedge LINK_CLK) begin
    latch_meta_r <= LINK_LATCH;
    latch_sync_r <= latch_meta_r;
    latch_prev_r <= latch_sync_r;
  end

  // capture word on latch rise; the frame sits two places up because
  // two more rises have shifted in by the time the latch is seen
  // transfer nine bits
  always_comb begin
    word_nxt = word_r;
    if (latch_sync_r && !latch_prev_r) begin
      word_nxt = shift_r[10:2];
    end
  end

  // latch level crosses one stage after the word, so the word is settled;
  // a level needs no reset in a domain whose clock may stand still
  always_ff @(posedge LINK_CLK) begin
    word_r <= word_nxt;
    latch_tog_r <= latch_prev_r;
  end

  // reference domain: toggle synchroniser and word hand-over
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      tog_meta_r <= 1'b0;
      tog_sync_r <= 1'b0;
      tog_prev_r <= 1'b0;
      word_sync1_r <= `DSP_WORD_RST;
      word_sync2_r <= `DSP_WORD_RST;
    end else begin
      tog_meta_r <= latch_tog_r;
      tog_sync_r <= tog_meta_r;
      tog_prev_r <= tog_sync_r;
      word_sync1_r <= word_r;
      word_sync2_r <= word_sync1_r;
    end
  end

  // word changes one link clock before the toggle and passes as many flip-flops, so the copy is safe
  assign latch_rise = tog_sync_r & ~tog_prev_r;

  // control word only changes on a latch event
  // hold old word
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (latch_rise) begin
      ctrl_nxt = word_sync2_r;
    end
  end

  // pins from outside pass two flip-flops
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      ctrl_r <= `DSP_WORD_RST;
      rst_meta_r <= 2'h0;
      rst_sync_r <= 2'h0;
      oc_meta_r <= 4'h0;
      oc_sync_r <= 4'h0;
      temp_meta_r <= 1'b0;
      temp_sync_r <= 1'b0;
      bg_meta_r <= 4'h0;
      bg_sync_r <= 4'h0;
      pl_meta_r <= 2'h0;
      pl_sync_r <= 2'h0;
      dead_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      rst_meta_r <= {CARD_RESET, ~CARD_RESET_N};
      rst_sync_r <= rst_meta_r;
      oc_meta_r <= OVERCURRENT_SENSE;
      oc_sync_r <= oc_meta_r;
      temp_meta_r <= OVER_TEMP;
      temp_sync_r <= temp_meta_r;
      bg_meta_r <= BELOW_GROUND;
      bg_sync_r <= bg_meta_r;
      pl_meta_r <= PROG_OUT_OF_LIMIT;
      pl_sync_r <= pl_meta_r;
      dead_r <= dead_nxt;
    end
  end

  // either reset input grounds the outputs; board ties the other inactive
  // one reset used
  assign card_rst = rst_sync_r[1] | rst_sync_r[0];

  // below ground sticks until the block is powered down (RSTN)
  // latch off state
  always_comb begin
    dead_nxt = dead_r | (|bg_sync_r);
  end

  assign pon = ctrl_r[`DSP_BIT_PON];

  // main supply decode, then prog decode with follow setting
  always_comb begin
    a_nxt.main_sel = DSP_GND;
    b_nxt.main_sel = DSP_GND;
    unique case ({ctrl_r[`DSP_BIT_A_MAIN_HI], ctrl_r[`DSP_BIT_A_MAIN_LO]})
      2'h1: a_nxt.main_sel = DSP_V3;
      2'h2: a_nxt.main_sel = DSP_V5;
      2'h0, 2'h3: a_nxt.main_sel = DSP_GND;
    endcase
    unique case ({ctrl_r[`DSP_BIT_B_MAIN_HI], ctrl_r[`DSP_BIT_B_MAIN_LO]})
      2'h1: b_nxt.main_sel = DSP_V3;
      2'h2: b_nxt.main_sel = DSP_V5;
      2'h0, 2'h3: b_nxt.main_sel = DSP_GND;
    endcase
    unique case ({ctrl_r[`DSP_BIT_A_PROG_HI], ctrl_r[`DSP_BIT_A_PROG_LO]})
      2'h0: a_nxt.prog_sel = DSP_GND;
      2'h1: a_nxt.prog_sel = a_nxt.main_sel;
      2'h2: a_nxt.prog_sel = DSP_V12;
      2'h3: a_nxt.prog_sel = DSP_HIZ;
    endcase
    unique case ({ctrl_r[`DSP_BIT_B_PROG_HI], ctrl_r[`DSP_BIT_B_PROG_LO]})
      2'h0: b_nxt.prog_sel = DSP_GND;
      2'h1: b_nxt.prog_sel = b_nxt.main_sel;
      2'h2: b_nxt.prog_sel = DSP_V12;
      2'h3: b_nxt.prog_sel = DSP_HIZ;
    endcase
    if (!pon || temp_sync_r || dead_r) begin
      a_nxt = {DSP_HIZ, DSP_HIZ};
      b_nxt = {DSP_HIZ, DSP_HIZ};
    end
    if (card_rst) begin
      a_nxt = {DSP_GND, DSP_GND};
      b_nxt = {DSP_GND, DSP_GND};
    end
  end

  // registered outputs
  // flag any overcurrent
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      a_r <= {DSP_GND, DSP_GND};
      b_r <= {DSP_GND, DSP_GND};
      lim_r <= 4'h0;
      quiet_r <= 1'b0;
      oc_n_r <= 1'b1;
      rdy_r <= 2'h0;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
      lim_r <= oc_sync_r;
      quiet_r <= ~pon & ~card_rst;
      oc_n_r <= ~(|oc_sync_r);
      rdy_r <= pl_sync_r;
    end
  end

  assign SLOT_A_CFG = a_r;
  assign SLOT_B_CFG = b_r;
  assign CURRENT_LIMIT_EN = lim_r;
  assign LOW_QUIESCENT = quiet_r;
  assign OVERCURRENT_FLAG_N = oc_n_r;
  assign SLOT_A_POWER_READY = rdy_r[0];
  assign SLOT_B_POWER_READY = rdy_r[1];
endmodule

//--- src/dsp_pkg.sv
// types for the dual-slot card power serial control block
// assumes dsp_consts.svh is on the include path
package dsp_pkg;
  // one output switch setting; codes stand for the closed switch
  typedef enum logic [2:0] {
    DSP_HIZ = 3'h0,
    DSP_GND = 3'h1,
    DSP_V3 = 3'h2,
    DSP_V5 = 3'h3,
    DSP_V12 = 3'h4
  } dsp_sel_t;
  // settings of one slot
  typedef struct packed {
    dsp_sel_t main_sel;
    dsp_sel_t prog_sel;
  } dsp_slot_t;
  // serial link pins
  typedef struct packed {
    logic data;
    logic clk_edge_unused;
    logic latch;
  } dsp_link_t;
endpackage
